// ---- dv/aod_link_asserts.sv ----
// Purpose: Concurrent checks on the detector to gain-control link
// Assumes: ce held high, calibration length given by CAL_CYCLES
// Notes: A counter bounds the calibration length check
`timescale 1ns/1ps
module aod_link_asserts #(
  parameter int CAL_CYCLES = aod_pkg::CAL_CYCLES_DEFAULT
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic sample_valid,
  input wire logic signed [aod_pkg::SAMPLE_W-1:0] sample_a,
  input wire logic signed [aod_pkg::SAMPLE_W-1:0] sample_b,
  input wire logic code_valid,
  input wire logic chan_a_upper_flag,
  input wire logic chan_a_lower_flag,
  input wire logic chan_b_upper_flag,
  input wire logic chan_b_lower_flag,
  input wire logic single_mode,
  input wire logic cal_busy,
  input wire logic cal_req
);
  logic [15:0] busy_cnt_q;

  default clocking @(posedge clk);
  endclocking
  default disable iff (rst);

  // Cleared when idle, so at the falling edge it still holds the busy length
  always_ff @(posedge clk)
  begin
    if (rst || !cal_busy)
      busy_cnt_q <= 16'h0000;
    else
      busy_cnt_q <= busy_cnt_q + 16'h0001;
  end

  property p_rst_clear;
    disable iff (1'b0)
    rst |=> !(chan_a_upper_flag || chan_a_lower_flag || chan_b_upper_flag || chan_b_lower_flag);
  endproperty
  a_rst_clear: assert property (p_rst_clear) else $error("flag high after reset");

  property p_full_a;
    sample_valid && !cal_busy && sample_a == 12'h800 |=> chan_a_upper_flag && chan_a_lower_flag;
  endproperty
  a_full_a: assert property (p_full_a) else $error("channel a full scale missed");

  property p_full_b;
    sample_valid && !cal_busy && sample_b == 12'h800 |=> chan_b_upper_flag && chan_b_lower_flag;
  endproperty
  a_full_b: assert property (p_full_b) else $error("channel b full scale missed");

  property p_hold_a;
    $rose(chan_a_lower_flag) |-> chan_a_lower_flag[*8];
  endproperty
  a_hold_a: assert property (p_hold_a) else $error("lower flag pulse too short");

  property p_hold_b;
    $rose(chan_b_upper_flag) |-> chan_b_upper_flag[*8];
  endproperty
  a_hold_b: assert property (p_hold_b) else $error("upper flag pulse too short");

  property p_cal_start;
    cal_req && !cal_busy |=> cal_busy;
  endproperty
  a_cal_start: assert property (p_cal_start) else $error("calibration not started");

  property p_cal_drop;
    cal_busy && sample_valid |=> !code_valid;
  endproperty
  a_cal_drop: assert property (p_cal_drop) else $error("sample taken while busy");

  property p_cal_len;
    $fell(cal_busy) |-> busy_cnt_q == CAL_CYCLES;
  endproperty
  a_cal_len: assert property (p_cal_len) else $error("calibration length wrong");

  property p_req_pulse;
    cal_req |=> !cal_req;
  endproperty
  a_req_pulse: assert property (p_req_pulse) else $error("request longer than a cycle");

  c_single_b: cover property (single_mode && chan_b_lower_flag);
  c_cal_end: cover property ($fell(cal_busy));
  c_hold_end: cover property ($fell(chan_a_lower_flag));
endmodule

// ---- dv/testbench.sv ----
// Purpose: Self-checking bench for the detector and gain-control pair
// Assumes: ce tied high, calibration shortened to 16 cycles
// Notes: Both APB slaves share one bus with separate selects
`timescale 1ns/1ps
module testbench;
  typedef struct {
    logic [11:0] a;
    logic [11:0] b;
    logic [10:0] up;
    logic [10:0] lo;
    logic [3:0] fl;
  } aod_row_t;
  logic clk, rst, psel_d, psel_h, penable, pwrite, sample_valid, code_valid;
  logic pready_d, pready_h, err_d, err_h, irq_d, irq_h, err;
  logic [7:0] paddr, temp_code, gain, g;
  logic [31:0] pwdata, prdata_d, prdata_h, rd;
  logic signed [11:0] sample_a, sample_b, code_a, code_b;
  int error_cnt, n_compared, n;
  // Limits and expected flags {b_lower, b_upper, a_lower, a_upper}
  aod_row_t rows[8] = '{
    '{12'h0E4, 12'h0E3, 11'h0E4, 11'h040, 4'hB},
    '{12'hF1C, 12'hFC0, 11'h0E4, 11'h040, 4'hB},
    '{12'h03F, 12'h800, 11'h0E4, 11'h040, 4'hC},
    '{12'h7FF, 12'hFC1, 11'h0E4, 11'h040, 4'h3},
    '{12'hF9C, 12'h032, 11'h064, 11'h032, 4'hB},
    '{12'h063, 12'hFCE, 11'h064, 11'h032, 4'hA},
    '{12'h800, 12'h801, 11'h7FF, 11'h7FF, 4'hF},
    '{12'h000, 12'h000, 11'h000, 11'h001, 4'h5}
  };

  aod_link_if link();
  aod_detector #(.CAL_CYCLES(16)) i_aod_detector (.clk(clk), .rst(rst), .ce(1'b1),
    .psel(psel_d), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata_d), .pready(pready_d), .pslverr(err_d), .irq(irq_d),
    .sample_valid(sample_valid), .sample_a(sample_a), .sample_b(sample_b),
    .code_a(code_a), .code_b(code_b), .code_valid(code_valid), .link(link));
  aod_gain_ctrl i_aod_gain_ctrl (.clk(clk), .rst(rst), .ce(1'b1), .psel(psel_h),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata_h),
    .pready(pready_h), .pslverr(err_h), .irq(irq_h), .temp_code(temp_code),
    .gain_level(gain), .link(link));
  aod_link_asserts #(.CAL_CYCLES(16)) i_aod_link_asserts (.clk(clk), .rst(rst),
    .sample_valid(sample_valid), .sample_a(sample_a), .sample_b(sample_b),
    .code_valid(code_valid), .chan_a_upper_flag(link.chan_a_upper_flag),
    .chan_a_lower_flag(link.chan_a_lower_flag), .chan_b_upper_flag(link.chan_b_upper_flag),
    .chan_b_lower_flag(link.chan_b_lower_flag), .single_mode(link.single_mode),
    .cal_busy(link.cal_busy), .cal_req(link.cal_req));

  initial
  begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  task automatic print_verdict;
    $display("compared %0d errors %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  function automatic logic [31:0] flags();
    return {28'h0, link.chan_b_lower_flag, link.chan_b_upper_flag,
      link.chan_a_lower_flag, link.chan_a_upper_flag};
  endfunction

  // Entered at a rising edge, returns one idle cycle later
  task automatic apb(input logic h, input logic wr, input logic [7:0] a, input logic [31:0] d);
    int k;
    psel_d <= !h;
    psel_h <= h;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    k = 0;
    do
    begin
      @(posedge clk);
      k++;
    end
    while ((h ? pready_h : pready_d) !== 1'b1 && k < 20);
    if ((h ? pready_h : pready_d) !== 1'b1)
    begin
      error_cnt++;
      print_verdict();
    end
    rd = h ? prdata_h : prdata_d;
    err = h ? err_h : err_d;
    psel_d <= 1'b0;
    psel_h <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask

  // One sample; returns at the falling edge of the first flag cycle
  task automatic hit(input logic [11:0] a, input logic [11:0] b);
    sample_a <= a;
    sample_b <= b;
    sample_valid <= 1'b1;
    @(posedge clk);
    sample_valid <= 1'b0;
    @(negedge clk);
  endtask

  task automatic wait_busy(input logic lvl);
    int k;
    k = 0;
    while (link.cal_busy !== lvl && k < 200)
    begin
      @(posedge clk);
      k++;
    end
    check({31'h0, link.cal_busy}, {31'h0, lvl});
    if (link.cal_busy !== lvl)
      print_verdict();
  endtask

  initial
  begin
    #800000;
    error_cnt++;
    print_verdict();
  end

  initial
  begin
    {rst, psel_d, psel_h, penable, pwrite, sample_valid} = 6'h20;
    {paddr, temp_code, pwdata, sample_a, sample_b} = '0;
    error_cnt = 0;
    n_compared = 0;
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    apb(0, 0, aod_pkg::DEV_LIMIT_OFS, '0);
    check(rd, 32'h004000E4);
    apb(0, 0, 8'h14, '0);
    check(rd | {31'h0, err}, 32'h00000001);
    apb(1, 0, aod_pkg::HST_STATUS_OFS, '0);
    check(rd & 32'h0000FF00, 32'h00008000);
    check(flags(), 32'h0);
    hit(12'h800, 12'h000);
    repeat (3) @(posedge clk);
    check({24'h0, gain}, 32'h0000007F);
    apb(0, 1, aod_pkg::DEV_IRQ_STAT_OFS, 32'h7);
    hit(12'h800, 12'h000);
    check({31'h0, irq_d}, 32'h0);
    @(posedge clk);
    apb(0, 0, aod_pkg::DEV_IRQ_STAT_OFS, '0);
    check(rd, 32'h00000003);
    apb(0, 1, aod_pkg::DEV_IRQ_MASK_OFS, 32'h1);
    check({31'h0, irq_d}, 32'h1);
    apb(0, 1, aod_pkg::DEV_IRQ_STAT_OFS, 32'h1);
    check({31'h0, irq_d}, 32'h0);
    // Host ignores channel B in dual mode and merges both cores in single mode
    for (int m = 0; m < 2; m++)
    begin
      apb(0, 1, aod_pkg::DEV_CTRL_OFS, m);
      hit(12'h000, 12'h800);
      @(posedge clk);
      apb(1, 0, aod_pkg::HST_STATUS_OFS, '0);
      check(rd & 32'h7, (m != 0) ? 32'h7 : 32'h0);
    end
    for (int m = 0; m < 2; m++)
    begin
      apb(0, 1, aod_pkg::DEV_CTRL_OFS, m);
      foreach (rows[i])
      begin
        apb(0, 1, aod_pkg::DEV_LIMIT_OFS, {5'h00, rows[i].lo, 5'h00, rows[i].up});
        hit(rows[i].a, rows[i].b);
        check(flags(), {28'h0, rows[i].fl});
        check({19'h0, code_valid, code_a}, {19'h0, 1'b1, rows[i].a});
        check({20'h0, code_b}, {20'h0, rows[i].b});
        check({31'h0, link.single_mode}, m);
        repeat (8) @(posedge clk);
        @(negedge clk);
        check(flags(), 32'h0);
        @(posedge clk);
      end
    end
    for (int s = 0; s < 8; s++)
    begin
      apb(0, 1, aod_pkg::DEV_CTRL_OFS, s << 1);
      hit(12'h800, 12'h000);
      n = 0;
      while (link.chan_a_lower_flag === 1'b1 && n < 2000)
      begin
        n++;
        @(negedge clk);
      end
      check(n, 8 << s);
      @(posedge clk);
    end
    apb(0, 1, aod_pkg::DEV_CTRL_OFS, 32'h0);
    hit(12'h800, 12'h800);
    repeat (4) @(negedge clk);
    @(posedge clk);
    hit(12'h800, 12'h800);
    repeat (7) @(negedge clk);
    check(flags(), 32'h0000000F);
    @(negedge clk);
    check(flags(), 32'h0);
    @(posedge clk);
    apb(0, 1, aod_pkg::DEV_CTRL_OFS, 32'h10);
    wait_busy(1'b1);
    hit(12'h800, 12'h800);
    check(flags() | {31'h0, code_valid}, 32'h0);
    wait_busy(1'b0);
    apb(0, 0, aod_pkg::DEV_IRQ_STAT_OFS, '0);
    check(rd & 32'h4, 32'h4);
    apb(1, 1, aod_pkg::HST_TEMP_DELTA_OFS, 32'h4);
    temp_code <= 8'h10;
    wait_busy(1'b1);
    wait_busy(1'b0);
    // Quiet lower flag should let the gain climb by one
    g = gain;
    apb(1, 1, aod_pkg::HST_QUIET_OFS, 32'h14);
    n = 0;
    while (gain === g && n < 200)
    begin
      @(posedge clk);
      n++;
    end
    check({24'h0, gain}, {24'h0, g + 8'h01});
    apb(1, 1, aod_pkg::HST_IRQ_MASK_OFS, 32'h1);
    check({31'h0, irq_h}, 32'h1);
    apb(1, 1, aod_pkg::HST_IRQ_STAT_OFS, 32'h1);
    check({31'h0, irq_h}, 32'h0);
    apb(1, 0, 8'h14, '0);
    check(rd | {31'h0, err}, 32'h00000001);
    hit(12'h800, 12'h800);
    @(posedge clk);
    rst <= 1'b1;
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    @(negedge clk);
    check(flags() | {gain, 24'h0}, 32'h80000000);
    print_verdict();
  end
endmodule

// ---- logic/aod_detector.sv ----
// Purpose: Two-channel overrange detector with hold timers and calibration control
// Assumes: One converted code per core per enabled clock, APB3 register access
// Notes: In single-channel mode sample_b carries the falling-edge conversion
//
// The implementer's own choices: the APB slave port and the register addresses.
`timescale 1ns/1ps
module aod_detector #(
  parameter int CAL_CYCLES = aod_pkg::CAL_CYCLES_DEFAULT
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic irq,
  input wire logic sample_valid,
  input wire logic signed [aod_pkg::SAMPLE_W-1:0] sample_a,
  input wire logic signed [aod_pkg::SAMPLE_W-1:0] sample_b,
  output logic signed [aod_pkg::SAMPLE_W-1:0] code_a,
  output logic signed [aod_pkg::SAMPLE_W-1:0] code_b,
  output logic code_valid,
  aod_link_if.dev link
);
  typedef enum logic [1:0] {
    AOD_IDLE = 2'b00,
    AOD_FG_CAL = 2'b01
  } aod_cal_t;

  function automatic logic [aod_pkg::MAG_W-1:0] aod_mag(
    input logic signed [aod_pkg::SAMPLE_W-1:0] s
  );
    logic [aod_pkg::SAMPLE_W-1:0] neg;
    neg = 12'h000 - s;
    if (!s[aod_pkg::SAMPLE_W-1])
      aod_mag = s[aod_pkg::MAG_W-1:0];
    else if (s == 12'h800)
      aod_mag = 11'h7FF;
    else
      aod_mag = neg[aod_pkg::MAG_W-1:0];
  endfunction

  function automatic logic [aod_pkg::HOLD_CNT_W-1:0] aod_hold_len(
    input logic [aod_pkg::HOLD_SEL_W-1:0] sel
  );
    logic [aod_pkg::HOLD_CNT_W-1:0] base;
    base = aod_pkg::HOLD_CNT_W'(aod_pkg::HOLD_BASE);
    aod_hold_len = base << sel;
  endfunction

  localparam logic [15:0] CAL_LAST = 16'(CAL_CYCLES - 1);

  logic single_q;
  logic [aod_pkg::HOLD_SEL_W-1:0] hold_sel_q;
  logic bg_cal_q;
  logic [aod_pkg::MAG_W-1:0] upper_limit_q;
  logic [aod_pkg::MAG_W-1:0] lower_limit_q;
  logic [aod_pkg::DEV_IRQ_W-1:0] irq_stat_q;
  logic [aod_pkg::DEV_IRQ_W-1:0] irq_mask_q;
  aod_cal_t cal_q;
  logic [15:0] cal_cnt_q;
  logic [aod_pkg::HOLD_CNT_W-1:0] cnt_q [2][2];
  logic flag_q [2][2];
  logic hit [2][2];
  logic [aod_pkg::MAG_W-1:0] mag [2];
  logic take;
  logic wr_en;
  logic fg_start;
  logic cal_done;
  logic mapped;

  assign wr_en = ce && psel && penable && pwrite;
  assign fg_start = (wr_en && paddr == aod_pkg::DEV_CTRL_OFS && pwdata[aod_pkg::CTRL_FG_CAL_BIT])
    || link.cal_req;
  assign cal_done = cal_q == AOD_FG_CAL && cal_cnt_q == CAL_LAST;
  // Converter offline while foreground calibration runs
  assign take = sample_valid && cal_q != AOD_FG_CAL;
  assign mag[0] = aod_mag(sample_a);
  assign mag[1] = aod_mag(sample_b);

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      single_q <= 1'b0;
      hold_sel_q <= 3'h0;
      bg_cal_q <= 1'b0;
      upper_limit_q <= aod_pkg::UPPER_LIMIT_RESET;
      lower_limit_q <= aod_pkg::LOWER_LIMIT_RESET;
      irq_mask_q <= 3'h0;
    end
    else if (wr_en)
    begin
      case (paddr)
        aod_pkg::DEV_CTRL_OFS:
        begin
          single_q <= pwdata[aod_pkg::CTRL_SINGLE_BIT];
          hold_sel_q <= pwdata[aod_pkg::CTRL_HOLD_LSB +: aod_pkg::HOLD_SEL_W];
          bg_cal_q <= pwdata[aod_pkg::CTRL_BG_CAL_BIT];
        end
        aod_pkg::DEV_LIMIT_OFS:
        begin
          upper_limit_q <= pwdata[aod_pkg::LIMIT_UPPER_LSB +: aod_pkg::MAG_W];
          lower_limit_q <= pwdata[aod_pkg::LIMIT_LOWER_LSB +: aod_pkg::MAG_W];
        end
        aod_pkg::DEV_IRQ_MASK_OFS: irq_mask_q <= pwdata[aod_pkg::DEV_IRQ_W-1:0];
        default: ;
      endcase
    end
  end

  // Foreground calibration sequencer; background mode never stalls sampling
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      cal_q <= AOD_IDLE;
      cal_cnt_q <= 16'h0000;
    end
    else if (ce)
    begin
      case (cal_q)
        AOD_IDLE:
        begin
          cal_cnt_q <= 16'h0000;
          if (fg_start)
            cal_q <= AOD_FG_CAL;
        end
        AOD_FG_CAL:
        begin
          cal_cnt_q <= cal_cnt_q + 16'h0001;
          if (cal_done)
            cal_q <= AOD_IDLE;
        end
        default: cal_q <= AOD_IDLE;
      endcase
    end
  end

  // Capture and pass on the two's complement codes
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      code_a <= 12'h000;
      code_b <= 12'h000;
      code_valid <= 1'b0;
    end
    else if (ce)
    begin
      code_valid <= take;
      if (take)
      begin
        code_a <= sample_a;
        code_b <= sample_b;
      end
    end
  end

  // Index c is the core or channel, t is 0 for upper and 1 for lower limit
  for (genvar c = 0; c < 2; c++)
  begin : g_chan
    // Same limit pair for both channels
    assign hit[c][0] = take && mag[c] >= upper_limit_q;
    assign hit[c][1] = take && mag[c] >= lower_limit_q;
    for (genvar t = 0; t < 2; t++)
    begin : g_thr
      // Restartable hold: flag stays high hold cycles after the last hit
      always_ff @(posedge clk)
      begin
        if (rst)
        begin
          cnt_q[c][t] <= 11'h000;
          flag_q[c][t] <= 1'b0;
        end
        else if (ce)
        begin
          if (hit[c][t])
            cnt_q[c][t] <= aod_hold_len(hold_sel_q);
          else if (cnt_q[c][t] != 11'h000)
            cnt_q[c][t] <= cnt_q[c][t] - 11'h001;
          flag_q[c][t] <= hit[c][t] || cnt_q[c][t] > 11'h001;
        end
      end
    end
  end

  // Each core owns its pair in both modes; the partner merges them in single mode only
  assign link.chan_a_upper_flag = flag_q[0][0];
  assign link.chan_a_lower_flag = flag_q[0][1];
  assign link.chan_b_upper_flag = flag_q[1][0];
  assign link.chan_b_lower_flag = flag_q[1][1];
  assign link.single_mode = single_q;
  assign link.cal_busy = cal_q == AOD_FG_CAL;

  // Sticky events; a new event beats a write-one clear in the same cycle
  always_ff @(posedge clk)
  begin
    if (rst)
      irq_stat_q <= 3'h0;
    else if (ce)
    begin
      if (wr_en && paddr == aod_pkg::DEV_IRQ_STAT_OFS)
        irq_stat_q <= (irq_stat_q & ~pwdata[aod_pkg::DEV_IRQ_W-1:0])
          | {cal_done, hit[0][1] || hit[1][1], hit[0][0] || hit[1][0]};
      else
        irq_stat_q <= irq_stat_q
          | {cal_done, hit[0][1] || hit[1][1], hit[0][0] || hit[1][0]};
    end
  end

  assign irq = |(irq_stat_q & irq_mask_q);

  always_comb
  begin
    mapped = 1'b1;
    prdata = 32'h0000_0000;
    case (paddr)
      aod_pkg::DEV_CTRL_OFS:
        prdata = {26'h0, bg_cal_q, 1'b0, hold_sel_q, single_q};
      aod_pkg::DEV_LIMIT_OFS:
        prdata = {5'h00, lower_limit_q, 5'h00, upper_limit_q};
      aod_pkg::DEV_STATUS_OFS:
        prdata = {26'h0, bg_cal_q, cal_q == AOD_FG_CAL,
          flag_q[1][1], flag_q[1][0], flag_q[0][1], flag_q[0][0]};
      aod_pkg::DEV_IRQ_STAT_OFS: prdata = {29'h0, irq_stat_q};
      aod_pkg::DEV_IRQ_MASK_OFS: prdata = {29'h0, irq_mask_q};
      default: mapped = 1'b0;
    endcase
  end

  // Zero wait states keeps the register path simple; stalls only via ce
  assign pready = ce;
  assign pslverr = psel && penable && !mapped;
endmodule

// ---- logic/aod_gain_ctrl.sv ----
// Purpose: Downstream gain management that watches the overrange flags
// Assumes: Same clock as the detector, APB3 register access
// Notes: Gain level saturates at both ends
`timescale 1ns/1ps
module aod_gain_ctrl (
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic irq,
  input wire logic [7:0] temp_code,
  output logic [aod_pkg::GAIN_W-1:0] gain_level,
  aod_link_if.host link
);
  logic upper_any;
  logic lower_any;
  logic upper_prev_q;
  logic [15:0] quiet_q;
  logic [15:0] quiet_cnt_q;
  logic [7:0] temp_delta_q;
  logic [7:0] temp_ref_q;
  logic busy_prev_q;
  logic pend_q;
  logic cal_req_q;
  logic [aod_pkg::HST_IRQ_W-1:0] irq_stat_q;
  logic [aod_pkg::HST_IRQ_W-1:0] irq_mask_q;
  logic wr_en;
  logic upper_rise;
  logic quiet_hit;
  logic cal_end;
  logic [7:0] drift;
  logic mapped;

  // In dual mode channel A rules the gain; single mode merges both cores
  assign upper_any = link.chan_a_upper_flag || (link.single_mode && link.chan_b_upper_flag);
  assign lower_any = link.chan_a_lower_flag || (link.single_mode && link.chan_b_lower_flag);
  assign wr_en = ce && psel && penable && pwrite;
  assign upper_rise = upper_any && !upper_prev_q;
  assign quiet_hit = !lower_any && quiet_cnt_q >= quiet_q;
  assign cal_end = busy_prev_q && !link.cal_busy;
  assign drift = temp_code >= temp_ref_q ? temp_code - temp_ref_q : temp_ref_q - temp_code;

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      quiet_q <= aod_pkg::QUIET_RESET;
      temp_delta_q <= aod_pkg::TEMP_DELTA_RESET;
      irq_mask_q <= 3'h0;
    end
    else if (wr_en)
    begin
      case (paddr)
        aod_pkg::HST_QUIET_OFS: quiet_q <= pwdata[15:0];
        aod_pkg::HST_TEMP_DELTA_OFS: temp_delta_q <= pwdata[7:0];
        aod_pkg::HST_IRQ_MASK_OFS: irq_mask_q <= pwdata[aod_pkg::HST_IRQ_W-1:0];
        default: ;
      endcase
    end
  end

  // Upper trip cuts gain before clipping; a long quiet lower flag raises it
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      upper_prev_q <= 1'b0;
      quiet_cnt_q <= 16'h0000;
      gain_level <= aod_pkg::GAIN_RESET;
    end
    else if (ce)
    begin
      upper_prev_q <= upper_any;
      if (lower_any || quiet_hit)
        quiet_cnt_q <= 16'h0000;
      else
        quiet_cnt_q <= quiet_cnt_q + 16'h0001;
      if (upper_rise && gain_level != 8'h00)
        gain_level <= gain_level - 8'h01;
      else if (quiet_hit && !upper_any && gain_level != 8'hFF)
        gain_level <= gain_level + 8'h01;
    end
  end

  // Drift since the last calibration triggers a new one; delta zero disables it
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      busy_prev_q <= 1'b0;
      pend_q <= 1'b0;
      cal_req_q <= 1'b0;
      temp_ref_q <= 8'h00;
    end
    else if (ce)
    begin
      busy_prev_q <= link.cal_busy;
      cal_req_q <= 1'b0;
      if (cal_end)
      begin
        pend_q <= 1'b0;
        temp_ref_q <= temp_code;
      end
      else if (!pend_q && temp_delta_q != 8'h00 && drift >= temp_delta_q)
      begin
        pend_q <= 1'b1;
        cal_req_q <= 1'b1;
      end
    end
  end

  assign link.cal_req = cal_req_q;

  always_ff @(posedge clk)
  begin
    if (rst)
      irq_stat_q <= 3'h0;
    else if (ce)
    begin
      if (wr_en && paddr == aod_pkg::HST_IRQ_STAT_OFS)
        irq_stat_q <= (irq_stat_q & ~pwdata[aod_pkg::HST_IRQ_W-1:0])
          | {cal_end, quiet_hit, upper_rise};
      else
        irq_stat_q <= irq_stat_q | {cal_end, quiet_hit, upper_rise};
    end
  end

  assign irq = |(irq_stat_q & irq_mask_q);

  always_comb
  begin
    mapped = 1'b1;
    prdata = 32'h0000_0000;
    case (paddr)
      aod_pkg::HST_QUIET_OFS: prdata = {16'h0000, quiet_q};
      aod_pkg::HST_TEMP_DELTA_OFS: prdata = {24'h000000, temp_delta_q};
      aod_pkg::HST_STATUS_OFS:
        prdata = {16'h0000, gain_level, 3'h0, pend_q, link.cal_busy,
          link.single_mode, lower_any, upper_any};
      aod_pkg::HST_IRQ_STAT_OFS: prdata = {29'h0, irq_stat_q};
      aod_pkg::HST_IRQ_MASK_OFS: prdata = {29'h0, irq_mask_q};
      default: mapped = 1'b0;
    endcase
  end

  assign pready = ce;
  assign pslverr = psel && penable && !mapped;
endmodule

// ---- logic/aod_link_if.sv ----
// Purpose: Wires between the overrange detector and the gain-control logic
// Assumes: Both ends run on the same clock
// Notes: Flags are levels; cal_req is a one-cycle pulse
`timescale 1ns/1ps
interface aod_link_if;
  logic chan_a_upper_flag;
  logic chan_a_lower_flag;
  logic chan_b_upper_flag;
  logic chan_b_lower_flag;
  logic single_mode;
  logic cal_busy;
  logic cal_req;

  modport dev (
    output chan_a_upper_flag,
    output chan_a_lower_flag,
    output chan_b_upper_flag,
    output chan_b_lower_flag,
    output single_mode,
    output cal_busy,
    input cal_req
  );

  modport host (
    input chan_a_upper_flag,
    input chan_a_lower_flag,
    input chan_b_upper_flag,
    input chan_b_lower_flag,
    input single_mode,
    input cal_busy,
    output cal_req
  );
endinterface

// ---- logic/aod_pkg.sv ----
// Purpose: Shared constants for the overrange detector and its gain-control partner
// Assumes: 12-bit two's complement samples, 32-bit APB data
// Notes: Register offsets are byte addresses, one aligned word each
package aod_pkg;
  localparam int SAMPLE_W = 12;
  localparam int MAG_W = 11;
  localparam int HOLD_SEL_W = 3;
  localparam int HOLD_BASE = 8;
  localparam int HOLD_CNT_W = 11;
  localparam int CAL_CYCLES_DEFAULT = 1024;
  localparam int GAIN_W = 8;

  // Device register map
  localparam logic [7:0] DEV_CTRL_OFS = 8'h00;
  localparam logic [7:0] DEV_LIMIT_OFS = 8'h04;
  localparam logic [7:0] DEV_STATUS_OFS = 8'h08;
  localparam logic [7:0] DEV_IRQ_STAT_OFS = 8'h0C;
  localparam logic [7:0] DEV_IRQ_MASK_OFS = 8'h10;
  localparam int CTRL_SINGLE_BIT = 0;
  localparam int CTRL_HOLD_LSB = 1;
  localparam int CTRL_FG_CAL_BIT = 4;
  localparam int CTRL_BG_CAL_BIT = 5;
  localparam int LIMIT_UPPER_LSB = 0;
  localparam int LIMIT_LOWER_LSB = 16;
  localparam logic [MAG_W-1:0] UPPER_LIMIT_RESET = 11'h0E4;
  localparam logic [MAG_W-1:0] LOWER_LIMIT_RESET = 11'h040;
  localparam int DEV_IRQ_W = 3;
  localparam int DEV_IRQ_UPPER = 0;
  localparam int DEV_IRQ_LOWER = 1;
  localparam int DEV_IRQ_CAL = 2;

  // Gain-controller register map
  localparam logic [7:0] HST_QUIET_OFS = 8'h00;
  localparam logic [7:0] HST_TEMP_DELTA_OFS = 8'h04;
  localparam logic [7:0] HST_STATUS_OFS = 8'h08;
  localparam logic [7:0] HST_IRQ_STAT_OFS = 8'h0C;
  localparam logic [7:0] HST_IRQ_MASK_OFS = 8'h10;
  localparam logic [15:0] QUIET_RESET = 16'hFFFF;
  localparam logic [7:0] TEMP_DELTA_RESET = 8'h00;
  localparam logic [GAIN_W-1:0] GAIN_RESET = 8'h80;
  localparam int HST_IRQ_W = 3;
  localparam int HST_IRQ_UPPER = 0;
  localparam int HST_IRQ_QUIET = 1;
  localparam int HST_IRQ_CAL = 2;
endpackage
